// ==== hw/scan_port_defines.vh ====
`ifndef SCAN_PORT_DEFINES_VH
`define SCAN_PORT_DEFINES_VH
`define IR_LEN          5
`define IR_CAPTURE_MARK 2'h1
`define INSTR_EXTEST    5'h01
`define INSTR_INTEST    5'h03
`define INSTR_CLAMP     5'h04
`define INSTR_SAMPLE    5'h05
`define INSTR_IDENTITY  5'h0E
`define INSTR_BIAS      5'h0F
`define INSTR_PAT0      5'h10
`define INSTR_DIS       5'h11
`define INSTR_SEQ       5'h12
`define INSTR_CTRL      5'h13
`define INSTR_PAT1      5'h14
`define INSTR_RSV_LO    5'h15
`define INSTR_RSV_HI    5'h1C
`define INSTR_ANA       5'h1D
`define INSTR_DIG       5'h1E
`define INSTR_BYPASS    5'h1F
`define SEL_BYP  4'h0
`define SEL_ID   4'h1
`define SEL_BSR  4'h2
`define SEL_BIAS 4'h3
`define SEL_PAT0 4'h4
`define SEL_DIS  4'h5
`define SEL_SEQ  4'h6
`define SEL_CTRL 4'h7
`define SEL_PAT1 4'h8
`define SEL_ANA  4'h9
`define SEL_DIG  4'hA
`define LEN_IR   10'h005
`define LEN_BYP  10'h001
`define LEN_ID   10'h020
`define LEN_BSR  10'h00A
`define LEN_BIAS 10'h080
`define LEN_MODE 10'h008
`define LEN_CTRL 10'h028
`define LEN_SEQ  10'h080
`define LEN_ROW  10'h280
`define SHIFT_MAX 640
`define BIAS_RESET 128'h0
`define DIG_RESET  8'h00
`define ANA_RESET  8'h00
`define CTRL_RESET 40'h00_27F0_0000
`define SEQ_RESET  128'h7FFF_0040_01C0_3C00_001C_6000_7FFF_FFFF
`define DIG_TST_INJ  7
`define DIG_HALF     6
`define DIG_DIFF_OFF 5
`define DIG_EXTRA    4
`define DIG_MKCLK    3
`define DIG_PATTERN  2
`define DIG_EXT_TRIG 1
`define DIG_INT_STRT 0
`define ANA_PLL      7
`define ANA_COLUMN   6
`define ANA_PIXSCAN  5
`define ANA_REF_OFF  4
`define ANA_HS       3
`define ANA_AMP      2
`define ANA_PULSE    1
`define ANA_DTEST    0
`define START_MIN_NS  2000
`define MCLK_NS       8
`define START_MIN_CYC ((`START_MIN_NS + `MCLK_NS - 1) / `MCLK_NS)
`endif

// ==== hw/scan_port_config_registers.v ====
`timescale 1ns/1ps
`include "scan_port_defines.vh"
module scan_port_config_registers #(
  parameter [31:0] IDENTITY_VALUE = 32'h1234_5671
) (
  input  wire         mclk,
  input  wire         reset_n,
  input  wire         tck,
  input  wire         tms,
  input  wire         tdi,
  output wire         tdo,
  output wire         tdo_oe_n,
  input  wire         pll_clock_in,
  input  wire         single_ended_clock_in,
  input  wire         differential_clock_in,
  input  wire         start_in,
  input  wire         marker_clock_select_in,
  input  wire         core_marker_clock,
  input  wire         core_readout_clock,
  input  wire         core_test_two,
  input  wire         core_test_one,
  output wire         analog_marker_clock_out,
  output wire         analog_readout_clock_out,
  output wire         test_pad_two,
  output wire         test_pad_one,
  output wire [127:0] bias_dac_codes,
  output wire         internal_test_inject_en,
  output wire         half_rows_en,
  output wire         diff_clock_off,
  output wire         extra_rows_en,
  output wire         marker_or_clock_sel,
  output wire         pattern_replace_en,
  output wire         external_trigger_en,
  output wire         readout_start,
  output wire         pll_en,
  output wire         analog_column_out_en,
  output wire         pixel_scan_en,
  output wire         reference_buffer_off,
  output wire         high_speed_en,
  output wire         pulse_amp_en,
  output wire         pulse_mode_en,
  output wire         discriminator_test_en,
  output wire [39:0]  readout_control,
  output wire [127:0] pixel_sequence_params,
  output wire [639:0] discriminator_disable_mask,
  output wire [639:0] row_pattern_zero,
  output wire [639:0] row_pattern_one
);

  localparam [3:0] ST_TLR  = 4'h0;
  localparam [3:0] ST_RTI  = 4'h1;
  localparam [3:0] ST_SDRS = 4'h2;
  localparam [3:0] ST_CDR  = 4'h3;
  localparam [3:0] ST_SDR  = 4'h4;
  localparam [3:0] ST_E1DR = 4'h5;
  localparam [3:0] ST_PDR  = 4'h6;
  localparam [3:0] ST_E2DR = 4'h7;
  localparam [3:0] ST_UDR  = 4'h8;
  localparam [3:0] ST_SIRS = 4'h9;
  localparam [3:0] ST_CIR  = 4'hA;
  localparam [3:0] ST_SIR  = 4'hB;
  localparam [3:0] ST_E1IR = 4'hC;
  localparam [3:0] ST_PIR  = 4'hD;
  localparam [3:0] ST_E2IR = 4'hE;
  localparam [3:0] ST_UIR  = 4'hF;

  // Instruction to data register selection
  function [3:0] sel_of;
    input [4:0] ir;
    begin
      if (ir == `INSTR_EXTEST || ir == `INSTR_INTEST || ir == `INSTR_SAMPLE)
        sel_of = `SEL_BSR;
      else if (ir == `INSTR_IDENTITY)
        sel_of = `SEL_ID;
      else if (ir == `INSTR_BIAS)
        sel_of = `SEL_BIAS;
      else if (ir == `INSTR_PAT0)
        sel_of = `SEL_PAT0;
      else if (ir == `INSTR_DIS)
        sel_of = `SEL_DIS;
      else if (ir == `INSTR_SEQ)
        sel_of = `SEL_SEQ;
      else if (ir == `INSTR_CTRL)
        sel_of = `SEL_CTRL;
      else if (ir == `INSTR_PAT1)
        sel_of = `SEL_PAT1;
      else if (ir == `INSTR_ANA)
        sel_of = `SEL_ANA;
      else if (ir == `INSTR_DIG)
        sel_of = `SEL_DIG;
      else
        sel_of = `SEL_BYP;
    end
  endfunction

  function [9:0] len_of;
    input [3:0] sel;
    begin
      if (sel == `SEL_ID)
        len_of = `LEN_ID;
      else if (sel == `SEL_BSR)
        len_of = `LEN_BSR;
      else if (sel == `SEL_BIAS || sel == `SEL_SEQ)
        len_of = `LEN_BIAS;
      else if (sel == `SEL_ANA || sel == `SEL_DIG)
        len_of = `LEN_MODE;
      else if (sel == `SEL_CTRL)
        len_of = `LEN_CTRL;
      else if (sel == `SEL_PAT0 || sel == `SEL_PAT1 || sel == `SEL_DIS)
        len_of = `LEN_ROW;
      else
        len_of = `LEN_BYP;
    end
  endfunction

  reg  [2:0]   tck_s_r;
  reg  [1:0]   tms_s_r;
  reg  [1:0]   tdi_s_r;
  reg  [4:0]   pin_m_r;
  reg  [4:0]   pin_s_r;
  reg  [3:0]   state_r;
  reg  [3:0]   state_nxt;
  reg  [4:0]   ir_r;
  reg  [9:0]   len_m1_r;
  reg  [639:0] sh_r;
  reg  [639:0] sh_nxt;
  reg  [639:0] cap;
  reg  [9:0]   pad_chain_r;
  reg  [127:0] bias_r;
  reg  [7:0]   dig_r;
  reg  [7:0]   ana_r;
  reg  [39:0]  ctrl_r;
  reg  [127:0] seq_r;
  reg  [639:0] dis_r;
  reg  [639:0] pat0_r;
  reg  [639:0] pat1_r;
  reg  [3:0]   pads_r;
  reg          tdo_r;
  reg          tdo_oe_n_r;
  reg          ext_d_r;
  reg          int_d_r;
  reg          start_r;
  wire         tck_rise;
  wire         tck_fall;
  wire         tms_s;
  wire         tdi_s;
  wire [3:0]   sel;
  wire         pads_from_chain;
  wire         start_ev;

  assign tck_rise = tck_s_r[1] & ~tck_s_r[2];
  assign tck_fall = ~tck_s_r[1] & tck_s_r[2];
  assign tms_s    = tms_s_r[1];
  assign tdi_s    = tdi_s_r[1];
  assign sel      = sel_of(ir_r);
  assign pads_from_chain = (ir_r == `INSTR_EXTEST) || (ir_r == `INSTR_CLAMP);

  // Two-flop synchronisers on the link pins and the five clock/start/select pins; core pad inputs are not synchronised
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tck_s_r <= 3'h0;
      tms_s_r <= 2'h3;
      tdi_s_r <= 2'h3;
      pin_m_r <= 5'h00;
      pin_s_r <= 5'h00;
    end else begin
      tck_s_r <= {tck_s_r[1:0], tck};
      tms_s_r <= {tms_s_r[0], tms};
      tdi_s_r <= {tdi_s_r[0], tdi};
      pin_m_r <= {pll_clock_in, single_ended_clock_in, differential_clock_in,
                  start_in, marker_clock_select_in};
      pin_s_r <= pin_m_r;
    end
  end

  // Tap state machine
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_TLR:  state_nxt = tms_s ? ST_TLR  : ST_RTI;
      ST_RTI:  state_nxt = tms_s ? ST_SDRS : ST_RTI;
      ST_SDRS: state_nxt = tms_s ? ST_SIRS : ST_CDR;
      ST_CDR:  state_nxt = tms_s ? ST_E1DR : ST_SDR;
      ST_SDR:  state_nxt = tms_s ? ST_E1DR : ST_SDR;
      ST_E1DR: state_nxt = tms_s ? ST_UDR  : ST_PDR;
      ST_PDR:  state_nxt = tms_s ? ST_E2DR : ST_PDR;
      ST_E2DR: state_nxt = tms_s ? ST_UDR  : ST_SDR;
      ST_UDR:  state_nxt = tms_s ? ST_SDRS : ST_RTI;
      ST_SIRS: state_nxt = tms_s ? ST_TLR  : ST_CIR;
      ST_CIR:  state_nxt = tms_s ? ST_E1IR : ST_SIR;
      ST_SIR:  state_nxt = tms_s ? ST_E1IR : ST_SIR;
      ST_E1IR: state_nxt = tms_s ? ST_UIR  : ST_PIR;
      ST_PIR:  state_nxt = tms_s ? ST_E2IR : ST_PIR;
      ST_E2IR: state_nxt = tms_s ? ST_UIR  : ST_SIR;
      ST_UIR:  state_nxt = tms_s ? ST_SDRS : ST_RTI;
      default: state_nxt = ST_TLR;
    endcase
  end

  // Capture values of the selected register
  always @* begin
    cap = 640'h0;
    case (sel)
      `SEL_ID:   cap[31:0]  = IDENTITY_VALUE;
      `SEL_BSR:  cap[9:0]   = {1'b0, pin_s_r, pads_r};
      `SEL_BIAS: cap[127:0] = bias_r;
      `SEL_DIG:  cap[7:0]   = dig_r;
      `SEL_ANA:  cap[7:0]   = ana_r;
      `SEL_CTRL: cap[39:0]  = ctrl_r;
      `SEL_SEQ:  cap[127:0] = seq_r;
      `SEL_DIS:  cap        = dis_r;
      `SEL_PAT0: cap        = pat0_r;
      `SEL_PAT1: cap        = pat1_r;
      default:   cap        = 640'h0;
    endcase
  end

  // Shift toward bit 0; new bit enters at top of active length
  always @* begin
    sh_nxt = {1'b0, sh_r[639:1]};
    sh_nxt[len_m1_r] = tdi_s;
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= ST_TLR;
      ir_r       <= `INSTR_IDENTITY;
      len_m1_r   <= 10'h000;
      sh_r       <= 640'h0;
      tdo_r      <= 1'b0;
      tdo_oe_n_r <= 1'b1;
    end else begin
      if (tck_rise) begin
        state_r <= state_nxt;
        if (state_r == ST_CDR) begin
          sh_r     <= cap;
          len_m1_r <= len_of(sel) - 10'h001;
        end else if (state_r == ST_CIR) begin
          sh_r     <= {635'h0, ir_r[4:2], `IR_CAPTURE_MARK};
          len_m1_r <= `LEN_IR - 10'h001;
        end else if (state_r == ST_SDR || state_r == ST_SIR) begin
          sh_r <= sh_nxt;
        end
      end
      if (state_r == ST_TLR)
        ir_r <= `INSTR_IDENTITY;
      else if (tck_fall && state_r == ST_UIR)
        ir_r <= sh_r[4:0];
      if (tck_fall) begin
        tdo_r      <= sh_r[0];
        tdo_oe_n_r <= ~(state_r == ST_SDR || state_r == ST_SIR);
      end
    end
  end

  // Update stages
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pad_chain_r <= 10'h000;
      bias_r      <= `BIAS_RESET;
      dig_r       <= `DIG_RESET;
      ana_r       <= `ANA_RESET;
      ctrl_r      <= `CTRL_RESET;
      seq_r       <= `SEQ_RESET;
      dis_r       <= 640'h0;
      pat0_r      <= 640'h0;
      pat1_r      <= 640'h0;
    end else if (tck_fall && state_r == ST_UDR) begin
      case (sel)
        `SEL_BSR:  pad_chain_r <= sh_r[9:0];
        `SEL_BIAS: bias_r      <= sh_r[127:0];
        `SEL_DIG:  dig_r       <= sh_r[7:0];
        `SEL_ANA:  ana_r       <= sh_r[7:0];
        `SEL_CTRL: ctrl_r      <= sh_r[39:0];
        `SEL_SEQ:  seq_r       <= sh_r[127:0];
        `SEL_DIS:  dis_r       <= sh_r;
        `SEL_PAT0: pat0_r      <= sh_r;
        `SEL_PAT1: pat1_r      <= sh_r;
        default:   pad_chain_r <= pad_chain_r;
      endcase
    end
  end

  // Output pads: from chain under external test or clamp, else core
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      pads_r <= 4'h0;
    else if (pads_from_chain)
      pads_r <= pad_chain_r[3:0];
    else
      pads_r <= {core_marker_clock, core_readout_clock, core_test_two, core_test_one};
  end

  // Readout start: external rising edge or internal bit going 0 to 1
  assign start_ev = dig_r[`DIG_EXT_TRIG] ? (pin_s_r[1] & ~ext_d_r)
                                         : (dig_r[`DIG_INT_STRT] & ~int_d_r);
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_d_r <= 1'b0;
      int_d_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      ext_d_r <= pin_s_r[1];
      int_d_r <= dig_r[`DIG_INT_STRT];
      start_r <= start_ev;
    end
  end

  assign tdo      = tdo_r;
  assign tdo_oe_n = tdo_oe_n_r;
  assign analog_marker_clock_out  = pads_r[3];
  assign analog_readout_clock_out = pads_r[2];
  assign test_pad_two             = pads_r[1];
  assign test_pad_one             = pads_r[0];
  assign bias_dac_codes           = bias_r;
  assign internal_test_inject_en  = dig_r[`DIG_TST_INJ];
  assign half_rows_en             = dig_r[`DIG_HALF];
  assign diff_clock_off           = dig_r[`DIG_DIFF_OFF];
  assign extra_rows_en            = dig_r[`DIG_EXTRA];
  assign marker_or_clock_sel      = dig_r[`DIG_MKCLK];
  assign pattern_replace_en       = dig_r[`DIG_PATTERN];
  assign external_trigger_en      = dig_r[`DIG_EXT_TRIG];
  assign readout_start            = start_r;
  assign pll_en                   = ana_r[`ANA_PLL];
  assign analog_column_out_en     = ana_r[`ANA_COLUMN];
  assign pixel_scan_en            = ana_r[`ANA_PIXSCAN];
  assign reference_buffer_off     = ana_r[`ANA_REF_OFF];
  assign high_speed_en            = ana_r[`ANA_HS];
  assign pulse_amp_en             = ana_r[`ANA_AMP];
  assign pulse_mode_en            = ana_r[`ANA_PULSE];
  assign discriminator_test_en    = ana_r[`ANA_DTEST];
  assign readout_control          = ctrl_r;
  assign pixel_sequence_params    = seq_r;
  assign discriminator_disable_mask = dis_r;
  assign row_pattern_zero         = pat0_r;
  assign row_pattern_one          = pat1_r;

endmodule

// ==== tb/jtag_host.sv ====
`timescale 1ns/1ps
module jtag_host (
  input  wire mclk,
  input  wire tdo,
  output reg  tck,
  output reg  tms,
  output reg  tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One 80 ns link clock period, idle low
  task tick(input logic t, input logic d, output logic o);
    @(posedge mclk) #1;
    tms = t;
    tdi = d;
    repeat (4) @(posedge mclk);
    #1;
    o = tdo;
    tck = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    tck = 1'b0;
  endtask
  // Five ticks with mode high, then idle state
  task tap_reset();
    logic o;
    repeat (5) tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
  endtask
  // Full scan from idle back to idle
  task scan(input bit ir, input int len, input logic [639:0] din,
            output logic [639:0] dout);
    logic o;
    dout = '0;
    tick(1'b1, ~tdi, o);
    if (ir) tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
    tick(1'b0, ~tdi, o);
    for (int i = 0; i < len; i++) begin
      tick(i == len - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
  endtask
endmodule

// ==== tb/scan_port_chk.sv ====
`timescale 1ns/1ps
module scan_port_chk (
  input wire         mclk,
  input wire         reset_n,
  input wire         tck,
  input wire         tdo,
  input wire         tdo_oe_n,
  input wire         start_in,
  input wire [127:0] bias_dac_codes,
  input wire         internal_test_inject_en,
  input wire         pll_en,
  input wire         external_trigger_en,
  input wire         readout_start,
  input wire [39:0]  readout_control
);
  logic       tck_q;
  logic [3:0] cnt;
  // Cycles since the link clock pin fell
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tck_q <= 1'b0;
      cnt   <= 4'hF;
    end else begin
      tck_q <= tck;
      if (tck_q && !tck) cnt <= 4'h0;
      else if (cnt != 4'hF) cnt <= cnt + 4'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  tdo_on_fall_a: assert property ($changed(tdo) |-> cnt <= 4'h5)
    else $error("serial out moved off a clock fall");
  oe_on_fall_a: assert property ($changed(tdo_oe_n) |-> !tck && cnt <= 4'h5)
    else $error("output enable moved off a clock fall");
  bias_hold_a: assert property (cnt > 4'h5 |-> $stable(bias_dac_codes))
    else $error("bias bank changed outside update");
  mode_hold_a: assert property ($changed({internal_test_inject_en, pll_en}) |-> cnt inside {[4'h1:4'h5]})
    else $error("mode bit changed outside update");
  ctrl_hold_a: assert property (tck |-> $stable(readout_control))
    else $error("control word changed while clock high");
  start_single_a: assert property (readout_start |=> !readout_start [*4])
    else $error("start pulse too long");
  start_cause_a: assert property (readout_start && !external_trigger_en |-> cnt <= 4'h7)
    else $error("internal start without a mode update");
  ext_start_a: assert property ($rose(start_in) && external_trigger_en |-> ##[1:6] readout_start)
    else $error("external start not followed by pulse");
  cover property ($rose(readout_start));
  cover property ($fell(tdo_oe_n));
  cover property ($changed(bias_dac_codes));
endmodule
bind scan_port_config_registers scan_port_chk u_chk (
  .mclk(mclk), .reset_n(reset_n), .tck(tck), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
  .start_in(start_in), .bias_dac_codes(bias_dac_codes),
  .internal_test_inject_en(internal_test_inject_en), .pll_en(pll_en),
  .external_trigger_en(external_trigger_en), .readout_start(readout_start),
  .readout_control(readout_control));

// ==== tb/test_scan_port_config_registers.sv ====
`timescale 1ns/1ps
module test_scan_port_config_registers;
  // Arbitrary identity value
  localparam logic [31:0]  ID_VAL = 32'hA5C3_0F01;
  localparam logic [127:0] PAT    = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  logic         mclk;
  logic         reset_n;
  logic [8:0]   pad_in;
  logic [639:0] so;
  logic [4:0]   prev;
  logic [4:0]   byp [6] = '{5'h1F, 5'h15, 5'h1C, 5'h02, 5'h00, 5'h04};
  logic [4:0]   rows [3] = '{5'h10, 5'h11, 5'h14};
  wire          oe_n;
  wire  [39:0]  ctrl;
  wire  [127:0] seq;
  wire  [639:0] dis, p0, p1;
  wire          tck, tms, tdi, tdo, rs;
  wire  [3:0]   pads;
  wire  [127:0] bias;
  wire  [7:1]   dig;
  wire  [7:0]   ana;
  int           err_total, total_checks, starts;
  `define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR %0t got %0h exp %0h", $time, got, exp); end end
  jtag_host host (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  scan_port_config_registers #(.IDENTITY_VALUE(ID_VAL)) dut (
    .mclk(mclk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(oe_n), .pll_clock_in(pad_in[8]), .single_ended_clock_in(pad_in[7]),
    .differential_clock_in(pad_in[6]), .start_in(pad_in[5]),
    .marker_clock_select_in(pad_in[4]), .core_marker_clock(pad_in[3]),
    .core_readout_clock(pad_in[2]), .core_test_two(pad_in[1]), .core_test_one(pad_in[0]),
    .analog_marker_clock_out(pads[3]), .analog_readout_clock_out(pads[2]),
    .test_pad_two(pads[1]), .test_pad_one(pads[0]), .bias_dac_codes(bias),
    .internal_test_inject_en(dig[7]), .half_rows_en(dig[6]), .diff_clock_off(dig[5]),
    .extra_rows_en(dig[4]), .marker_or_clock_sel(dig[3]), .pattern_replace_en(dig[2]),
    .external_trigger_en(dig[1]), .readout_start(rs), .pll_en(ana[7]),
    .analog_column_out_en(ana[6]), .pixel_scan_en(ana[5]), .reference_buffer_off(ana[4]),
    .high_speed_en(ana[3]), .pulse_amp_en(ana[2]), .pulse_mode_en(ana[1]),
    .discriminator_test_en(ana[0]), .readout_control(ctrl), .pixel_sequence_params(seq),
    .discriminator_disable_mask(dis), .row_pattern_zero(p0), .row_pattern_one(p1));
  task load_ir(input logic [4:0] code);
    host.scan(1'b1, 5, {635'h0, code}, so);
  endtask
  task dr(input int len, input logic [639:0] din);
    host.scan(1'b0, len, din, so);
  endtask
  task tally_and_finish();
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) if (rs === 1'b1) starts++;
  initial begin
    #600000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    reset_n = 1'b0;
    pad_in = 9'h000;
    err_total = 0;
    total_checks = 0;
    starts = 0;
    prev = 5'h0E;
    repeat (3) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    host.tap_reset();
    dr(32, '0);
    `CHECK(so[31:0], ID_VAL)
    foreach (byp[i]) begin
      load_ir(byp[i]);
      `CHECK(so[4:0], {prev[4:2], 2'b01})
      prev = byp[i];
      dr(3, 640'h5);
      `CHECK(so[2:0], 3'b010)
    end
    load_ir(5'h0F);
    dr(128, {512'h0, PAT});
    `CHECK(so[127:0], 128'h0)
    `CHECK(bias, PAT)
    dr(128, '0);
    `CHECK(so[127:0], PAT)
    `CHECK(bias, 128'h0)
    for (int m = 0; m < 2; m++) begin
      load_ir(m ? 5'h1D : 5'h1E);
      for (int i = 0; i < 8; i++) begin
        dr(8, 640'h1 << i);
        `CHECK(so[7:0], i ? 8'h1 << (i - 1) : 8'h0)
        `CHECK(m ? ana : {dig, 1'b0}, m ? 8'h1 << i : 8'hFE & (8'h1 << i))
      end
    end
    `CHECK(starts, 1)
    load_ir(5'h1E);
    dr(8, 640'h2);
    pad_in[5] = 1'b1;
    repeat (250) @(posedge mclk);
    #1 pad_in[5] = 1'b0;
    repeat (8) @(posedge mclk);
    `CHECK(starts, 2)
    pad_in = 9'h15B;
    load_ir(5'h05);
    dr(10, 640'h005);
    `CHECK(so[9:0], 10'h15B)
    `CHECK(pads, 4'hB)
    load_ir(5'h01);
    `CHECK(pads, 4'h5)
    load_ir(5'h13);
    dr(40, 640'hA5_5A00_C3F1);
    `CHECK(so[39:0], 40'h00_27F0_0000)
    `CHECK(ctrl, 40'hA5_5A00_C3F1)
    load_ir(5'h12);
    dr(128, {512'h0, PAT});
    `CHECK(so[127:0], 128'h7FFF_0040_01C0_3C00_001C_6000_7FFF_FFFF)
    `CHECK(seq, PAT)
    for (int r = 0; r < 3; r++) begin
      load_ir(rows[r]);
      dr(640, {5{PAT}});
      `CHECK(so, 640'h0)
      `CHECK(r == 0 ? p0 : (r == 1 ? dis : p1), {5{PAT}})
    end
    `CHECK(oe_n, 1'b1)
    host.tap_reset();
    dr(32, '0);
    `CHECK(so[31:0], ID_VAL)
    tally_and_finish();
  end
endmodule
